/* verilog/malc_pkg.sv */
// constants for the extended max-address command interpreter
package malc_pkg;
	// ********************************************************
	// register byte offsets on the wishbone slave
	// ********************************************************
	localparam logic [7:0] OFS_FEATURE = 8'h00;
	localparam logic [7:0] OFS_SECCOUNT = 8'h04;
	localparam logic [7:0] OFS_SECNUM = 8'h08;
	localparam logic [7:0] OFS_CYLLOW = 8'h0C;
	localparam logic [7:0] OFS_CYLHIGH = 8'h10;
	localparam logic [7:0] OFS_DEVHEAD = 8'h14;
	localparam logic [7:0] OFS_DEVCTL = 8'h18;
	localparam logic [7:0] OFS_COMMAND = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_ERROR = 8'h24;
	localparam logic [7:0] OFS_MAXLO = 8'h28;
	localparam logic [7:0] OFS_MAXHI = 8'h2C;
	localparam logic [7:0] OFS_IDW60 = 8'h30;
	localparam logic [7:0] OFS_IDW100 = 8'h34;
	localparam logic [7:0] OFS_IDW102 = 8'h38;
	// ********************************************************
	// opcodes and subcommand features
	// ********************************************************
	localparam logic [7:0] OP_SETMAX_EXT = 8'h37;
	localparam logic [7:0] OP_RDNATIVE_EXT = 8'h27;
	localparam logic [7:0] OP_SETMAX = 8'hF9;
	localparam logic [7:0] OP_RDNATIVE = 8'hF8;
	localparam logic [7:0] FEAT_SETPW = 8'h01;
	localparam logic [7:0] FEAT_LOCK = 8'h02;
	localparam logic [7:0] FEAT_UNLOCK = 8'h03;
	localparam logic [7:0] FEAT_FREEZE = 8'h04;
	// ********************************************************
	// field positions and reset values
	// ********************************************************
	localparam int STS_BSY = 7;
	localparam int STS_RDY = 6;
	localparam int STS_ERR = 0;
	localparam int ERR_ABT = 2;
	localparam int CTL_HOB = 7;
	localparam int SC_PERSIST = 0;
	localparam logic [7:0] STATUS_RESET = 8'h40;
	localparam logic [7:0] ERROR_RESET = 8'h00;
	localparam logic [47:0] LBA28_LIMIT = 48'h0000_0FFF_FFFF;
	localparam logic [47:0] NATIVE_MAX_DEFAULT = 48'h0000_1000_0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage

/* verilog/malc_max_address_limit_control.sv */
// extended max-address and freeze-lock command interpreter with wb slave
//
// Operation
// R1: feature 04h with F9h means freeze-lock
// R2: F9h after F8h is an address set
// R3: after freeze-lock reject every set-max command
// R4: opcode 37h is the extended set-max
// R5: abort any access beyond accepted maximum
// R6: above 28-bit limit update words 103:100 only
// R7: at or below limit update both word groups
// R8: abort if unsupported or above native capacity
// R9: abort if 28-bit protected area exists
// R10: abort unless previous command was 27h
// R11: host issues 27h right before 37h
// R12: abort while locked or frozen
// R13: abort nonvolatile request in offset mode
// R14: only one nonvolatile set per reset
// R15: sector count bit 0 picks persistence
// R16: persistent maximum survives power-on reset
// R17: maximum taken from current/previous taskfile bytes
// R18: maximum returned in same bytes by hob
// R19: locked state rejects all but unlock, freeze
// R20: aborts set abt and err, clear bsy
// R21: frozen state clears only at power cycle
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module malc_max_address_limit_control #(
	parameter logic [47:0] NATIVE_MAX = malc_pkg::NATIVE_MAX_DEFAULT,
	parameter bit EXT_SUPPORTED = 1'b1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// classic wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	// state from neighbouring firmware blocks
	input wire logic lockedState,
	input wire logic offsetMode,
	input wire logic hpa28Exists,
	// nonvolatile maximum store
	input wire logic nvStoredValid,
	input wire logic [47:0] nvStoredLba,
	output logic nvWrite,
	output logic [47:0] nvWriteLba,
	// media access check
	input wire logic accReq,
	input wire logic [47:0] accLba,
	output logic accGrant,
	output logic accAbort,
	// frozen indication
	output logic frozen
);
	// ********************************************************
	// taskfile and state
	// ********************************************************
	logic [7:0] feature;
	logic [15:0] secCount, secNum, cylLow, cylHigh;
	logic [7:0] devHead, devCtl, status, errorReg;
	logic [7:0] cmdOpcode, lastCmd;
	logic cmdPending;
	logic [47:0] maxLba;
	logic [31:0] idW60;
	logic [47:0] idW100;
	logic nvUsed, hpaBy28;
	logic busWrite, busRead;
	logic [47:0] reqLba;
	logic abortExt, abortF9, isFreeze, isAddrSet;
	logic doneOk, doneAbort;

	// byte picked by hob from a current/previous pair
	function automatic logic [7:0] hobPick(input logic [15:0] pair,
		input logic hob);
		hobPick = hob ? pair[15:8] : pair[7:0];
	endfunction

	// clamp a maximum to the 28-bit identify words
	function automatic logic [31:0] id28(input logic [47:0] lba);
		id28 = (lba > malc_pkg::LBA28_LIMIT) ?
			malc_pkg::LBA28_LIMIT[31:0] : lba[31:0];
	endfunction

	assign busWrite = wbCyc & wbStb & wbWe & ~wbAck & wbSel[0];
	assign busRead = wbCyc & wbStb & ~wbWe & ~wbAck;

	// 48-bit request assembled from current and previous bytes [R17]
	assign reqLba = {cylHigh[15:8], cylLow[15:8], secNum[15:8],
		cylHigh[7:0], cylLow[7:0], secNum[7:0]};

	// ********************************************************
	// command decode
	// ********************************************************
	// every abort of the extended set-max, one term per cause
	always_comb begin
		abortExt = 1'b0;
		if (!EXT_SUPPORTED || reqLba > NATIVE_MAX)
			abortExt = 1'b1; // [R8]
		if (hpa28Exists || hpaBy28)
			abortExt = 1'b1; // [R9]
		if (lastCmd != malc_pkg::OP_RDNATIVE_EXT)
			abortExt = 1'b1; // [R10] [R11]
		if (lockedState || frozen)
			abortExt = 1'b1; // [R12]
		if (secCount[malc_pkg::SC_PERSIST] && offsetMode)
			abortExt = 1'b1; // [R13]
		if (secCount[malc_pkg::SC_PERSIST] && nvUsed)
			abortExt = 1'b1; // [R14]
	end

	// F9h: address set after F8h, otherwise a subcommand by feature
	assign isAddrSet = lastCmd == malc_pkg::OP_RDNATIVE; // [R2]
	assign isFreeze = !isAddrSet &&
		feature == malc_pkg::FEAT_FREEZE; // [R1]

	always_comb begin
		abortF9 = 1'b0;
		if (frozen)
			abortF9 = 1'b1; // [R3]
		else if (lockedState && (isAddrSet ||
			(feature != malc_pkg::FEAT_UNLOCK && !isFreeze)))
			abortF9 = 1'b1; // [R19]
		else if (isAddrSet && {20'h00000, devHead[3:0],
			cylHigh[7:0], cylLow[7:0], secNum[7:0]} > NATIVE_MAX)
			abortF9 = 1'b1;
		else if (!isAddrSet && (feature < malc_pkg::FEAT_SETPW ||
			feature > malc_pkg::FEAT_FREEZE))
			abortF9 = 1'b1;
	end

	// outcome of the pending command
	always_comb begin
		doneOk = 1'b0;
		doneAbort = 1'b0;
		if (cmdPending) begin
			unique case (cmdOpcode)
				malc_pkg::OP_SETMAX_EXT: begin // [R4]
					doneAbort = abortExt;
					doneOk = ~abortExt;
				end
				malc_pkg::OP_SETMAX: begin
					doneAbort = abortF9;
					doneOk = ~abortF9;
				end
				malc_pkg::OP_RDNATIVE_EXT, malc_pkg::OP_RDNATIVE: begin
					doneOk = 1'b1;
				end
				default: begin
					doneAbort = 1'b1;
				end
			endcase
		end
	end

	// ********************************************************
	// wishbone slave
	// ********************************************************
	// ack one cycle after the strobe, dropped in the next cycle
	always_ff @(posedge clk_sys) begin
		if (rst)
			wbAck <= 1'b0;
		else
			wbAck <= wbCyc & wbStb & ~wbAck;
	end

	// read mux, upper bytes of narrow registers read as zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wbDatR <= malc_pkg::READ_UNMAPPED;
		end else if (busRead) begin
			case (wbAdr)
				malc_pkg::OFS_FEATURE: wbDatR <= {24'h000000, feature};
				malc_pkg::OFS_SECCOUNT: wbDatR <= {24'h000000,
					hobPick(secCount, devCtl[malc_pkg::CTL_HOB])};
				malc_pkg::OFS_SECNUM: wbDatR <= {24'h000000,
					hobPick(secNum, devCtl[malc_pkg::CTL_HOB])}; // [R18]
				malc_pkg::OFS_CYLLOW: wbDatR <= {24'h000000,
					hobPick(cylLow, devCtl[malc_pkg::CTL_HOB])}; // [R18]
				malc_pkg::OFS_CYLHIGH: wbDatR <= {24'h000000,
					hobPick(cylHigh, devCtl[malc_pkg::CTL_HOB])}; // [R18]
				malc_pkg::OFS_DEVHEAD: wbDatR <= {24'h000000, devHead};
				malc_pkg::OFS_DEVCTL: wbDatR <= {24'h000000, devCtl};
				malc_pkg::OFS_COMMAND: wbDatR <= {24'h000000, cmdOpcode};
				malc_pkg::OFS_STATUS: wbDatR <= {24'h000000, status};
				malc_pkg::OFS_ERROR: wbDatR <= {24'h000000, errorReg};
				malc_pkg::OFS_MAXLO: wbDatR <= maxLba[31:0];
				malc_pkg::OFS_MAXHI: wbDatR <= {16'h0000, maxLba[47:32]};
				malc_pkg::OFS_IDW60: wbDatR <= idW60;
				malc_pkg::OFS_IDW100: wbDatR <= idW100[31:0];
				malc_pkg::OFS_IDW102: wbDatR <= {16'h0000, idW100[47:32]};
				default: wbDatR <= malc_pkg::READ_UNMAPPED;
			endcase
		end
	end

	// ********************************************************
	// taskfile registers
	// ********************************************************
	// host writes push the old current byte into previous; a completed
	// read-native returns its value in the same byte positions
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			feature <= 8'h00;
			secCount <= 16'h0000;
			secNum <= 16'h0000;
			cylLow <= 16'h0000;
			cylHigh <= 16'h0000;
			devHead <= 8'h00;
			devCtl <= 8'h00;
		end else if (busWrite) begin
			case (wbAdr)
				malc_pkg::OFS_FEATURE: feature <= wbDatW[7:0];
				malc_pkg::OFS_SECCOUNT: secCount <= {secCount[7:0],
					wbDatW[7:0]}; // [R15]
				malc_pkg::OFS_SECNUM: secNum <= {secNum[7:0], wbDatW[7:0]};
				malc_pkg::OFS_CYLLOW: cylLow <= {cylLow[7:0], wbDatW[7:0]};
				malc_pkg::OFS_CYLHIGH: cylHigh <= {cylHigh[7:0],
					wbDatW[7:0]};
				malc_pkg::OFS_DEVHEAD: devHead <= wbDatW[7:0];
				malc_pkg::OFS_DEVCTL: devCtl <= wbDatW[7:0];
				default: begin
				end
			endcase
		end else if (doneOk && cmdOpcode == malc_pkg::OP_RDNATIVE_EXT) begin
			secNum <= {NATIVE_MAX[31:24], NATIVE_MAX[7:0]};
			cylLow <= {NATIVE_MAX[39:32], NATIVE_MAX[15:8]};
			cylHigh <= {NATIVE_MAX[47:40], NATIVE_MAX[23:16]};
		end else if (doneOk && cmdOpcode == malc_pkg::OP_RDNATIVE) begin
			secNum[7:0] <= NATIVE_MAX[7:0];
			cylLow[7:0] <= NATIVE_MAX[15:8];
			cylHigh[7:0] <= NATIVE_MAX[23:16];
			devHead[3:0] <= NATIVE_MAX[27:24];
		end
	end

	// ********************************************************
	// command sequencing
	// ********************************************************
	// a command write latches the opcode and raises busy for one cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmdOpcode <= 8'h00;
			cmdPending <= 1'b0;
		end else begin
			cmdPending <= busWrite && wbAdr == malc_pkg::OFS_COMMAND;
			if (busWrite && wbAdr == malc_pkg::OFS_COMMAND)
				cmdOpcode <= wbDatW[7:0];
		end
	end

	// previous opcode, cleared by reset so a set after reset aborts
	always_ff @(posedge clk_sys) begin
		if (rst)
			lastCmd <= 8'h00;
		else if (cmdPending)
			lastCmd <= cmdOpcode; // [R10]
	end

	// status and error after each command or refused access
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status <= malc_pkg::STATUS_RESET;
			errorReg <= malc_pkg::ERROR_RESET;
		end else if (doneAbort || (accReq && accLba > maxLba)) begin
			status <= 8'h41; // [R20] abort wins over a new command
			errorReg <= 8'h04; // [R20] [R5]
		end else if (busWrite && wbAdr == malc_pkg::OFS_COMMAND) begin
			status <= 8'h80;
			errorReg <= 8'h00;
		end else if (doneOk) begin
			status <= malc_pkg::STATUS_RESET;
		end
	end

	// ********************************************************
	// maximum address, identify words, persistence
	// ********************************************************
	// reset stands for power-on: reload the stored maximum when kept
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			maxLba <= nvStoredValid ? nvStoredLba : NATIVE_MAX; // [R16]
			idW100 <= nvStoredValid ? nvStoredLba : NATIVE_MAX;
			idW60 <= id28(nvStoredValid ? nvStoredLba : NATIVE_MAX);
		end else if (doneOk && cmdOpcode == malc_pkg::OP_SETMAX_EXT) begin
			maxLba <= reqLba;
			idW100 <= reqLba; // [R6] [R7]
			if (reqLba <= malc_pkg::LBA28_LIMIT)
				idW60 <= reqLba[31:0]; // [R7]
		end else if (doneOk && cmdOpcode == malc_pkg::OP_SETMAX &&
			isAddrSet) begin
			maxLba <= {20'h00000, devHead[3:0], cylHigh[7:0],
				cylLow[7:0], secNum[7:0]}; // [R2]
			idW100 <= {20'h00000, devHead[3:0], cylHigh[7:0],
				cylLow[7:0], secNum[7:0]};
			idW60 <= {4'h0, devHead[3:0], cylHigh[7:0], cylLow[7:0],
				secNum[7:0]};
		end
	end

	// nonvolatile store request; volatile sets never raise nvWrite
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nvWrite <= 1'b0;
			nvWriteLba <= 48'h0000_0000_0000;
			nvUsed <= 1'b0;
		end else begin
			nvWrite <= 1'b0;
			if (doneOk && cmdOpcode == malc_pkg::OP_SETMAX_EXT &&
				secCount[malc_pkg::SC_PERSIST]) begin
				nvWrite <= 1'b1; // [R16]
				nvWriteLba <= reqLba;
				nvUsed <= 1'b1; // [R14]
			end
		end
	end

	// a 28-bit address set establishes a protected area
	always_ff @(posedge clk_sys) begin
		if (rst)
			hpaBy28 <= 1'b0;
		else if (doneOk && cmdOpcode == malc_pkg::OP_SETMAX && isAddrSet)
			hpaBy28 <= 1'b1; // [R9]
	end

	// frozen stays until reset, no command can clear it
	always_ff @(posedge clk_sys) begin
		if (rst)
			frozen <= 1'b0; // [R21]
		else if (doneOk && cmdOpcode == malc_pkg::OP_SETMAX && isFreeze)
			frozen <= 1'b1; // [R3]
	end

	// ********************************************************
	// media access check
	// ********************************************************
	// registered verdict one cycle after each request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			accGrant <= 1'b0;
			accAbort <= 1'b0;
		end else begin
			accGrant <= accReq && accLba <= maxLba;
			accAbort <= accReq && accLba > maxLba; // [R5]
		end
	end
endmodule
`default_nettype wire

/* tb/malc_nv_store.sv */
// nonvolatile maximum store beside the interpreter
`timescale 1ns/1ps
`default_nettype none
module malc_nv_store (
	// clock
	input wire logic clk_sys,
	// store request
	input wire logic nvWrite,
	input wire logic [47:0] nvWriteLba,
	// stored value
	output logic nvStoredValid,
	output logic [47:0] nvStoredLba
);
	// no reset here: the value has to outlive power-on reset
	initial nvStoredValid = 1'b0;
	initial nvStoredLba = 48'hAAAA_AAAA_AAAA;
	// take the value on the store pulse
	always @(posedge clk_sys) begin
		if (nvWrite) begin
			nvStoredValid <= 1'b1;
			nvStoredLba <= nvWriteLba;
		end
	end
endmodule
`default_nettype wire

/* tb/malc_checker_sva.sv */
// port checker for the max-address interpreter
`timescale 1ns/1ps
`default_nettype none
module malc_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register bus
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbAck,
	// access and state
	input wire logic accReq,
	input wire logic accGrant,
	input wire logic accAbort,
	input wire logic nvWrite,
	input wire logic frozen
);
	// ********************************
	// timing and state relations
	// ********************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [1:0] nvCount;
	// saturates so a runaway store pulse cannot wrap back to legal
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nvCount <= 2'h0;
		end else if (nvWrite && nvCount != 2'h3) begin
			nvCount <= nvCount + 2'h1;
		end
	end
	sequence busReq; wbCyc && wbStb && !wbAck; endsequence
	sequence ackPulse; wbAck ##1 !wbAck; endsequence
	sequence cmdDone; wbAck || $past(wbAck); endsequence
	ack_next_cycle_a: assert property (busReq |=> ackPulse)
		else $error("ack late or too long");
	acc_answer_a: assert property (accReq |=> accGrant != accAbort)
		else $error("access not answered once");
	acc_quiet_a: assert property (!accReq |=> !accGrant && !accAbort)
		else $error("access answer without request");
	nv_once_a: assert property (nvCount <= 2'h1)
		else $error("second nonvolatile store");
	nv_after_cmd_a: assert property (nvWrite |->
		$past(wbAck) || $past(wbAck, 2) || $past(wbAck, 3))
		else $error("store without command");
	frozen_hold_a: assert property (frozen |=> frozen)
		else $error("frozen state left");
	frozen_cleared_a: assert property ($past(rst) |-> !frozen)
		else $error("frozen kept over reset");
	frozen_by_cmd_a: assert property ($rose(frozen) |-> cmdDone)
		else $error("frozen without command");
endmodule
bind malc_max_address_limit_control malc_checker i_chk (.clk_sys(clk_sys),
	.rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .accReq(accReq),
	.accGrant(accGrant), .accAbort(accAbort), .nvWrite(nvWrite),
	.frozen(frozen));
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the max-address interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys, rst, wbCyc, wbStb, wbWe, wbAck, lockedState, offsetMode;
	logic hpa28Exists, nvStoredValid, nvWrite, accReq, accGrant, accAbort;
	logic frozen;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatW, wbDatR, rd;
	logic [47:0] nvStoredLba, nvWriteLba, accLba;
	int nErrors = 0;
	int comparisons = 0;
	localparam logic [47:0] NATIVE = 48'h0012_3456_789A;
	typedef struct packed {logic [47:0] lba; logic b; logic [7:0] sts;
		logic [31:0] w60; logic [47:0] max;} malc_row_type;
	// boundary values around the 28-bit limit and the native capacity, then two persistent sets
	malc_row_type rows [5] = '{
		'{48'h0000_0FFF_FFFF, 1'b0, 8'h40, 32'h0FFF_FFFF, 48'h0000_0FFF_FFFF},
		'{NATIVE, 1'b0, 8'h40, 32'h0FFF_FFFF, NATIVE},
		'{48'h0012_3456_789B, 1'b0, 8'h41, 32'h0FFF_FFFF, NATIVE},
		'{48'h0000_0123_4567, 1'b1, 8'h40, 32'h0123_4567, 48'h0000_0123_4567},
		'{48'h0000_0000_1000, 1'b1, 8'h41, 32'h0123_4567, 48'h0000_0123_4567}};
	malc_max_address_limit_control #(.NATIVE_MAX(NATIVE),
		.EXT_SUPPORTED(1'b1)) i_dut (.clk_sys(clk_sys), .rst(rst),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
		.wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
		.lockedState(lockedState), .offsetMode(offsetMode),
		.hpa28Exists(hpa28Exists), .nvStoredValid(nvStoredValid),
		.nvStoredLba(nvStoredLba), .nvWrite(nvWrite),
		.nvWriteLba(nvWriteLba), .accReq(accReq), .accLba(accLba),
		.accGrant(accGrant), .accAbort(accAbort), .frozen(frozen));
	malc_nv_store i_nv (.clk_sys(clk_sys), .nvWrite(nvWrite),
		.nvWriteLba(nvWriteLba), .nvStoredValid(nvStoredValid),
		.nvStoredLba(nvStoredLba));
	// ********************************
	// bus and check tasks
	// ********************************
	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nErrors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one classic cycle; holds everything until ack is sampled
	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatW <= {24'h000000, d};
		do @(posedge clk_sys); while (wbAck !== 1'b1);
		rd = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic look(input logic [7:0] a, input logic [47:0] exp);
		bus(1'b0, a, 8'h00);
		chk({16'h0000, rd}, exp);
	endtask
	task automatic setmax(input logic [47:0] m, input logic b, input logic n);
		if (n)
			bus(1'b1, malc_pkg::OFS_COMMAND,
				malc_pkg::OP_RDNATIVE_EXT);
		bus(1'b1, malc_pkg::OFS_SECCOUNT, {7'h00, b});
		bus(1'b1, malc_pkg::OFS_SECNUM, m[31:24]);
		bus(1'b1, malc_pkg::OFS_SECNUM, m[7:0]);
		bus(1'b1, malc_pkg::OFS_CYLLOW, m[39:32]);
		bus(1'b1, malc_pkg::OFS_CYLLOW, m[15:8]);
		bus(1'b1, malc_pkg::OFS_CYLHIGH, m[47:40]);
		bus(1'b1, malc_pkg::OFS_CYLHIGH, m[23:16]);
		bus(1'b1, malc_pkg::OFS_COMMAND, malc_pkg::OP_SETMAX_EXT);
	endtask
	task automatic sub(input logic [7:0] f, input logic [47:0] sts);
		bus(1'b1, malc_pkg::OFS_FEATURE, f);
		bus(1'b1, malc_pkg::OFS_COMMAND, malc_pkg::OP_SETMAX);
		look(malc_pkg::OFS_STATUS, sts);
	endtask
	// a grant comes back as 1, an abort as 2
	task automatic access(input logic [47:0] m, input logic [47:0] exp);
		@(posedge clk_sys);
		accReq <= 1'b1;
		accLba <= m;
		@(posedge clk_sys);
		accReq <= 1'b0;
		@(posedge clk_sys);
		chk({46'h0, accAbort, accGrant}, exp);
	endtask
	task automatic hold_reset;
		rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
	endtask
	// ********************************
	// clock, watchdog and sequence
	// ********************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// the sequence needs a few hundred cycles
	initial begin
		repeat (30000) @(posedge clk_sys);
		nErrors++;
		complete_run();
	end
	initial begin
		{rst, wbCyc, wbStb, wbWe, lockedState, offsetMode} = 6'h20;
		{hpa28Exists, accReq, wbAdr, wbDatW, accLba} = '0;
		wbSel = 4'hF;
		hold_reset();
		foreach (rows[i]) begin
			setmax(rows[i].lba, rows[i].b, 1'b1);
			look(malc_pkg::OFS_STATUS, rows[i].sts);
			look(malc_pkg::OFS_ERROR, rows[i].sts[0] ? 48'h4 : 48'h0);
			look(malc_pkg::OFS_IDW60, rows[i].w60);
			look(malc_pkg::OFS_IDW100, rows[i].max[31:0]);
			look(malc_pkg::OFS_IDW102, rows[i].max[47:32]);
		end
		setmax(NATIVE, 1'b0, 1'b1);
		bus(1'b1, malc_pkg::OFS_DEVCTL, 8'h80);
		look(malc_pkg::OFS_CYLLOW, 48'h12);
		bus(1'b1, malc_pkg::OFS_DEVCTL, 8'h00);
		look(malc_pkg::OFS_SECNUM, 48'h9A);
		access(NATIVE, 48'h1);
		access(NATIVE + 48'h1, 48'h2);
		look(malc_pkg::OFS_STATUS, 48'h41);
		setmax(48'h1000, 1'b0, 1'b0);
		look(malc_pkg::OFS_STATUS, 48'h41);
		hpa28Exists <= 1'b1;
		setmax(48'h1000, 1'b0, 1'b1);
		look(malc_pkg::OFS_STATUS, 48'h41);
		hpa28Exists <= 1'b0;
		lockedState <= 1'b1;
		setmax(48'h1000, 1'b0, 1'b1);
		look(malc_pkg::OFS_STATUS, 48'h41);
		sub(malc_pkg::FEAT_SETPW, 48'h41);
		sub(malc_pkg::FEAT_FREEZE, 48'h40);
		lockedState <= 1'b0;
		chk(frozen, 1'b1);
		setmax(48'h1000, 1'b0, 1'b1);
		look(malc_pkg::OFS_STATUS, 48'h41);
		sub(malc_pkg::FEAT_UNLOCK, 48'h41);
		hold_reset();
		chk(frozen, 1'b0);
		access(48'h0000_0123_4568, 48'h2);
		access(48'h0000_0123_4567, 48'h1);
		offsetMode <= 1'b1;
		setmax(48'h1000, 1'b1, 1'b1);
		look(malc_pkg::OFS_STATUS, 48'h41);
		offsetMode <= 1'b0;
		setmax(48'h2000, 1'b1, 1'b1);
		look(malc_pkg::OFS_STATUS, 48'h40);
		bus(1'b1, malc_pkg::OFS_COMMAND, malc_pkg::OP_RDNATIVE);
		sub(malc_pkg::FEAT_FREEZE, 48'h40);
		chk(frozen, 1'b0);
		setmax(48'h1000, 1'b0, 1'b1);
		look(malc_pkg::OFS_STATUS, 48'h41);
		look(malc_pkg::OFS_MAXLO, 48'h0000_0456_789A);
		look(malc_pkg::OFS_MAXHI, 48'h0);
		sub(8'h05, 48'h41);
		bus(1'b1, malc_pkg::OFS_COMMAND, 8'hC6);
		look(malc_pkg::OFS_STATUS, 48'h41);
		complete_run();
	end
endmodule
`default_nettype wire
